// ==== common/npt_defines.svh ====
// Constants for the next-page transmit register block
// Notes on behaviour
// (RULE1) Bit 15 requests another next page, resets 0
// (RULE2) Bit 14 reserved: writes dropped, reads zero
// (RULE3) Bit 13 selects message or unformatted page
// (RULE4) Bit 12 comply acknowledge, writable, resets 0
// (RULE5) Bit 11 read-only toggle, inverse of previous
// (RULE6) Code field writable, resets to null page
// (RULE7) Writes leave toggle unchanged, other fields update; code updates them only in bytes whose write strobe is set
`ifndef NPT_DEFINES_SVH
`define NPT_DEFINES_SVH

// Register index and byte address (index times four)
`define NPT_IDX_NEXT_PAGE_TX   8'h07
`define NPT_ADDR_NEXT_PAGE_TX  8'h1C
`define NPT_ADDR_W             8

// Field positions
`define NPT_BIT_NEXT_PAGE      15
`define NPT_BIT_RESERVED       14
`define NPT_BIT_MSG_PAGE       13
`define NPT_BIT_COMPLY         12
`define NPT_BIT_TOGGLE         11
`define NPT_CODE_MSB           10
`define NPT_CODE_LSB           0

// Reset values
`define NPT_RST_NEXT_PAGE      1'h0
`define NPT_RST_MSG_PAGE       1'h1
`define NPT_RST_COMPLY         1'h0
`define NPT_RST_TOGGLE         1'h0
`define NPT_RST_CODE           11'h001

// Bus responses
`define NPT_RESP_OKAY          2'h0
`define NPT_RESP_DECERR        2'h3

`endif

// ==== common/npt_pkg.sv ====
// Types shared by the next-page transmit register block
package npt_pkg;

	typedef logic [15:0] npt_word_t;
	typedef logic [1:0]  npt_resp_t;

	// Register bank and bus slave state
	typedef struct packed {
		logic        aw_held;
		logic [7:0]  aw_addr;
		logic        w_held;
		logic [15:0] w_data;
		logic [1:0]  w_strb;
		logic        bvalid;
		npt_resp_t   bresp;
		logic        rvalid;
		logic [31:0] rdata;
		npt_resp_t   rresp;
		logic        next_page_request;
		logic        message_page_select;
		logic        comply_acknowledge;
		logic [10:0] code;
	} npt_reg_state_t;

	// Toggle tracker state
	typedef struct packed {
		logic toggle;
	} npt_tog_state_t;

endpackage

// ==== common/npt_arb_if.sv ====
// Link code word exchange signals between register bank and toggle tracker
`timescale 1ns/1ps
interface npt_arb_if;
	logic exchanged;       // One-cycle pulse: a link code word was exchanged
	logic exchanged_tog;   // Toggle bit carried by that word
	logic toggle;          // Toggle to send in the next word

	modport bank (output exchanged, output exchanged_tog, input toggle);
	modport tracker (input exchanged, input exchanged_tog, output toggle);
endinterface

// ==== rtl/npt_toggle_track.sv ====
// Toggle bit tracker driven by the arbitration exchange events
`timescale 1ns/1ps
`include "npt_defines.svh"
module npt_toggle_track (
	input  wire logic     aclk,
	input  wire logic     aresetn,
	npt_arb_if.tracker    arb
);
	import npt_pkg::*;

	npt_tog_state_t s;
	npt_tog_state_t next_s;

	// Toggle takes the inverse of the last exchanged toggle bit
	always_comb begin
		next_s = s;
		if (arb.exchanged) begin
			next_s.toggle = ~arb.exchanged_tog; // RULE5
		end
	end

	// State register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s.toggle <= `NPT_RST_TOGGLE; // RULE5
		end else begin
			s <= next_s;
		end
	end

	assign arb.toggle = s.toggle;
endmodule

// ==== rtl/npt_next_page_reg.sv ====
// Next-page transmit register with an AXI4-Lite slave port
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "npt_defines.svh"
module npt_next_page_reg (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [7:0]        s_axi_awaddr,
	input  wire logic [2:0]        s_axi_awprot,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output npt_pkg::npt_resp_t     s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [7:0]        s_axi_araddr,
	input  wire logic [2:0]        s_axi_arprot,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output npt_pkg::npt_resp_t     s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic              lcw_exchanged,
	input  wire logic              lcw_exchanged_toggle,
	output npt_pkg::npt_word_t     next_page_tx_word
);
	import npt_pkg::*;

	npt_reg_state_t s;
	npt_reg_state_t next_s;
	npt_arb_if      arb ();

	////////////////////////////////////////////////////////////////////////////
	// Toggle tracker

	assign arb.exchanged     = lcw_exchanged;
	assign arb.exchanged_tog = lcw_exchanged_toggle;

	npt_toggle_track u_toggle (
		.aclk    (aclk),
		.aresetn (aresetn),
		.arb     (arb)
	);

	////////////////////////////////////////////////////////////////////////////
	// Register image

	// Assemble the 16-bit word from stored fields and the live toggle
	function automatic npt_word_t npt_image(input npt_reg_state_t st, input logic tog);
		npt_word_t w;
		w = 16'h0000;
		w[`NPT_BIT_NEXT_PAGE] = st.next_page_request; // RULE1
		w[`NPT_BIT_RESERVED]  = 1'b0; // RULE2
		w[`NPT_BIT_MSG_PAGE]  = st.message_page_select; // RULE3
		w[`NPT_BIT_COMPLY]    = st.comply_acknowledge; // RULE4
		w[`NPT_BIT_TOGGLE]    = tog; // RULE5
		w[`NPT_CODE_MSB:`NPT_CODE_LSB] = st.code; // RULE6
		return w;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Bus handshakes

	// Write address and write data each hold one beat until the write is done; read address waits while rvalid is set
	assign s_axi_awready = !s.aw_held;
	assign s_axi_wready  = !s.w_held;
	assign s_axi_arready = !s.rvalid;

	////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		next_s = s;

		// Response channels drop once taken
		if (s.bvalid && s_axi_bready) begin
			next_s.bvalid = 1'b0;
		end
		if (s.rvalid && s_axi_rready) begin
			next_s.rvalid = 1'b0;
		end

		// Capture write address and write data in either order
		if (!s.aw_held && s_axi_awvalid) begin
			next_s.aw_held = 1'b1;
			next_s.aw_addr = s_axi_awaddr;
		end
		if (!s.w_held && s_axi_wvalid) begin
			next_s.w_held = 1'b1;
			next_s.w_data = s_axi_wdata[15:0];
			next_s.w_strb = s_axi_wstrb[1:0];
		end

		// Perform the write once both halves are held and no response waits
		if (s.aw_held && s.w_held && !s.bvalid) begin
			next_s.aw_held = 1'b0;
			next_s.w_held  = 1'b0;
			next_s.bvalid  = 1'b1;
			if ({s.aw_addr[7:2], 2'b00} == `NPT_ADDR_NEXT_PAGE_TX) begin
				next_s.bresp = `NPT_RESP_OKAY;
				if (s.w_strb[1]) begin // RULE2 RULE7
					next_s.next_page_request   = s.w_data[`NPT_BIT_NEXT_PAGE]; // RULE1
					next_s.message_page_select = s.w_data[`NPT_BIT_MSG_PAGE]; // RULE3
					next_s.comply_acknowledge  = s.w_data[`NPT_BIT_COMPLY]; // RULE4
					next_s.code[10:8]          = s.w_data[10:8]; // RULE6
				end
				if (s.w_strb[0]) begin
					next_s.code[7:0] = s.w_data[7:0]; // RULE6
				end
				// Bits 14 and 11 of the write data are dropped
			end else begin
				next_s.bresp = `NPT_RESP_DECERR;
			end
		end

		// Read: answer one cycle after the address is taken
		if (s_axi_arvalid && !s.rvalid) begin
			next_s.rvalid = 1'b1;
			if ({s_axi_araddr[7:2], 2'b00} == `NPT_ADDR_NEXT_PAGE_TX) begin
				next_s.rdata = {16'h0000, npt_image(s, arb.toggle)}; // RULE2
				next_s.rresp = `NPT_RESP_OKAY;
			end else begin
				next_s.rdata = 32'h00000000;
				next_s.rresp = `NPT_RESP_DECERR;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// State register

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s.aw_held             <= 1'b0;
			s.aw_addr             <= 8'h00;
			s.w_held              <= 1'b0;
			s.w_data              <= 16'h0000;
			s.w_strb              <= 2'h0;
			s.bvalid              <= 1'b0;
			s.bresp               <= `NPT_RESP_OKAY;
			s.rvalid              <= 1'b0;
			s.rdata               <= 32'h00000000;
			s.rresp               <= `NPT_RESP_OKAY;
			s.next_page_request   <= `NPT_RST_NEXT_PAGE; // RULE1
			s.message_page_select <= `NPT_RST_MSG_PAGE; // RULE3
			s.comply_acknowledge  <= `NPT_RST_COMPLY; // RULE4
			s.code                <= `NPT_RST_CODE; // RULE6
		end else begin
			s <= next_s;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign s_axi_bvalid      = s.bvalid;
	assign s_axi_bresp       = s.bresp;
	assign s_axi_rvalid      = s.rvalid;
	assign s_axi_rdata       = s.rdata;
	assign s_axi_rresp       = s.rresp;
	assign next_page_tx_word = npt_image(s, arb.toggle); // Word sent in the next page
endmodule

// ==== dv/npt_next_page_reg_checker.sv ====
// Assertions on the next-page transmit register ports
`timescale 1ns/1ps
module npt_next_page_reg_checker (
	input wire logic               aclk,
	input wire logic               aresetn,
	input wire logic [7:0]         s_axi_araddr,
	input wire logic               s_axi_arvalid,
	input wire logic               s_axi_arready,
	input wire logic               s_axi_rvalid,
	input wire logic [31:0]        s_axi_rdata,
	input wire npt_pkg::npt_resp_t s_axi_rresp,
	input wire logic               lcw_exchanged,
	input wire logic               lcw_exchanged_toggle,
	input wire npt_pkg::npt_word_t next_page_tx_word
);
	import npt_pkg::*;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic rd_take;
	// Read request taken this edge
	assign rd_take = s_axi_arvalid && s_axi_arready;
	////////////////////////////////////////
	// Word contents
	AST_RSV_ZERO: assert property (next_page_tx_word[14] == 1'h0)
		else $error("reserved bit set");
	AST_RST_WORD: assert property ($rose(aresetn) |-> next_page_tx_word == 16'h2001)
		else $error("reset word wrong");
	AST_TOG_FLIP: assert property (lcw_exchanged |=>
		next_page_tx_word[11] != $past(lcw_exchanged_toggle))
		else $error("toggle not inverse");
	AST_TOG_HOLD: assert property (!lcw_exchanged |=> $stable(next_page_tx_word[11]))
		else $error("toggle moved");
	////////////////////////////////////////
	// Read answers
	AST_RD_MAP: assert property (rd_take && s_axi_araddr[7:2] == 6'h07 |=>
		s_axi_rvalid && s_axi_rresp == 2'h0 &&
		s_axi_rdata == {16'h0, $past(next_page_tx_word)})
		else $error("read data wrong");
	AST_RD_UNMAP: assert property (rd_take && s_axi_araddr[7:2] != 6'h07 |=>
		s_axi_rresp == 2'h3 && s_axi_rdata == 32'h0)
		else $error("unmapped read wrong");
	AST_RD_RSV: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0 && !s_axi_rdata[14])
		else $error("read reserved set");
endmodule
bind npt_next_page_reg npt_next_page_reg_checker u_chk (.aclk, .aresetn, .s_axi_araddr,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rdata, .s_axi_rresp, .lcw_exchanged,
	.lcw_exchanged_toggle, .next_page_tx_word);

// ==== dv/npt_next_page_reg_tb.sv ====
// Self-checking bench for the next-page transmit register
`timescale 1ns/1ps
module npt_next_page_reg_tb;
	import npt_pkg::*;
	logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
	logic s_axi_bready = 1, s_axi_rready = 1, lcw_exchanged = 0, lcw_exchanged_toggle = 0;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0;
	logic [3:0] s_axi_wstrb = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, d, v;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, tog_e = 0;
	npt_resp_t s_axi_bresp, s_axi_rresp, r;
	npt_word_t next_page_tx_word, e = 16'h2001;
	integer seed = 32'hF5B9C716, n_mismatch = 0, checks = 0, n = 0;
	npt_next_page_reg uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.lcw_exchanged, .lcw_exchanged_toggle, .next_page_tx_word);
	// Clock
	initial forever #25 aclk = ~aclk;
	////////////////////////////////////////
	// Expected word after a write
	function automatic npt_word_t nxt(input npt_word_t o, dv, input logic [1:0] s);
		npt_word_t m;
		m = {{8{s[1]}}, {8{s[0]}}} & 16'hB7FF;
		return (o & ~m) | (dv & m);
	endfunction
	task automatic cmp(input string what, input logic [31:0] exp, got);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task tally_and_finish;
		$display("checks %0d n_mismatch %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	////////////////////////////////////////
	// Bus cycles
	task wr(input logic [7:0] a, input logic [31:0] dv, input logic [3:0] s);
		s_axi_awaddr <= a;
		s_axi_wdata <= dv;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'h0;
			if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'h0;
		end while (!s_axi_bvalid);
		r = s_axi_bresp;
	endtask
	task rd(input logic [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'h0;
		end while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
	endtask
	// Write, then read back without the toggle bit
	task wr_chk(input logic [7:0] a, input logic [31:0] dv, input logic [3:0] s);
		wr(a, dv, s);
		cmp("bresp", a[7:2] == 6'h07 ? 2'h0 : 2'h3, r);
		if (a[7:2] == 6'h07) e = nxt(e, dv[15:0], s[1:0]);
		rd(8'h1C);
		cmp("word", {16'h0, e}, d & 32'hFFFFF7FF);
	endtask
	////////////////////////////////////////
	// Exchange pulses, back to back at times, and toggle tracking
	always @(posedge aclk) begin
		n <= n + 1;
		lcw_exchanged <= n > 20 && n % 5 < 2;
		lcw_exchanged_toggle <= n[2];
		if (!aresetn) tog_e <= 1'h0;
		else if (lcw_exchanged) tog_e <= ~lcw_exchanged_toggle;
		if (aresetn) cmp("toggle", {31'h0, tog_e},
			{28'h0, next_page_tx_word[14:11] & 4'h9});
	end
	// Main sequence
	initial begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		rd(8'h1C);
		cmp("reset word", 32'h2001, d);
		wr_chk(8'h1C, 32'hFFFFFFFF, 4'hF);
		wr_chk(8'h1F, 32'h0, 4'h1);
		wr_chk(8'h1C, 32'h0, 4'hE);
		wr_chk(8'h18, 32'h0, 4'hF);
		repeat (30) begin
			v = $random(seed);
			wr_chk(v[0] ? {6'h07, v[2:1]} : v[15:8], $random(seed), v[19:16]);
			rd(v[15:8]);
			cmp("rresp", v[15:10] == 6'h07 ? 2'h0 : 2'h3, r);
		end
		tally_and_finish;
	end
	// Watchdog
	initial begin
		repeat (5000) @(posedge aclk);
		n_mismatch++;
		tally_and_finish;
	end
endmodule
